// ### hw/mpr_params.svh
// Offsets, field positions, reset values and region count.
// Behaviour
// - Valid clear: base goes to selected region.
// - Valid set: region number loads, then base.
// - Valid bit always reads back as zero.
// - Region field reads the region number register.
// - Attribute register takes word and halfword accesses.
// - Bit 28 forbids instruction fetch when set.
// - Bits 15..8 disable subregions, one each.
// - Region size is two to size plus one.
// - Largest size code means base is zero.
// - Base field spans bits 31 down to N.
// - Attributes apply to selected region; bit 0 enables.
// - Permission, type extension, S, C, B bit positions.
// - Aliases behave exactly like primary registers.
// - Eight regions, region numbers 0 to 7.
`ifndef MPR_PARAMS_SVH
`define MPR_PARAMS_SVH

`define MPR_OFS_REGION_NUMBER   8'h98
`define MPR_OFS_BASE            8'h9C
`define MPR_OFS_ATTR            8'hA0
`define MPR_OFS_BASE_ALIAS_ONE  8'hA4
`define MPR_OFS_ATTR_ALIAS_ONE  8'hA8

`define MPR_REGIONS             8
`define MPR_BASE_LOW_BIT        5
`define MPR_BASE_VALID_BIT      4
`define MPR_REGION_MSB          2

`define MPR_XN_BIT              28
`define MPR_AP_LSB              24
`define MPR_TEX_LSB             19
`define MPR_S_BIT               18
`define MPR_C_BIT               17
`define MPR_B_BIT               16
`define MPR_SRD_LSB             8
`define MPR_SIZE_LSB            1
`define MPR_ENABLE_BIT          0

`define MPR_RESET_WORD          32'h0000_0000
`define MPR_RESET_REGION        3'h0

`endif

// ### hw/mpr_pkg.sv
// Types shared by the region configuration registers.
package mpr_pkg;

  typedef struct packed {
    logic       no_execute;
    logic [2:0] access_permission;
    logic [2:0] type_extension;
    logic       shareable;
    logic       cacheable;
    logic       bufferable;
    logic [7:0] subregion_disable;
    logic [4:0] size;
    logic       enable;
  } mpr_attr_t;

  typedef struct packed {
    logic [31:0] base;
    mpr_attr_t   attr;
  } mpr_region_t;

endpackage

// ### hw/mpr_region_regs.sv
// Region base and attribute registers, with aliases, for eight regions.
`timescale 1ns/1ps
`include "mpr_params.svh"

module mpr_region_regs (
  input  wire logic                       CLOCK,
  input  wire logic                       RST_N,
  input  wire logic [7:0]                 BUS_ADDR,
  input  wire logic [31:0]                BUS_WDATA,
  input  wire logic                       BUS_WRITE,
  input  wire logic                       BUS_READ,
  input  wire logic                       BUS_HALF,
  output logic [31:0]                     BUS_RDATA,
  output logic [2:0]                      REGION_SEL,
  output mpr_pkg::mpr_region_t [7:0]      REGION_CFG
);

  // Converts stored attributes to the register layout.
  function automatic logic [31:0] attr_to_word(input mpr_pkg::mpr_attr_t a);
    logic [31:0] w;
    w = `MPR_RESET_WORD;
    w[`MPR_XN_BIT] = a.no_execute;
    w[`MPR_AP_LSB +: 3] = a.access_permission;
    w[`MPR_TEX_LSB +: 3] = a.type_extension;
    w[`MPR_S_BIT] = a.shareable;
    w[`MPR_C_BIT] = a.cacheable;
    w[`MPR_B_BIT] = a.bufferable;
    w[`MPR_SRD_LSB +: 8] = a.subregion_disable;
    w[`MPR_SIZE_LSB +: 5] = a.size;
    w[`MPR_ENABLE_BIT] = a.enable;
    return w;
  endfunction

  // Picks the attribute fields out of a written word; other bits drop.
  function automatic mpr_pkg::mpr_attr_t word_to_attr(input logic [31:0] w);
    mpr_pkg::mpr_attr_t a;
    a.no_execute = w[`MPR_XN_BIT];
    a.access_permission = w[`MPR_AP_LSB +: 3];
    a.type_extension = w[`MPR_TEX_LSB +: 3];
    a.shareable = w[`MPR_S_BIT];
    a.cacheable = w[`MPR_C_BIT];
    a.bufferable = w[`MPR_B_BIT];
    a.subregion_disable = w[`MPR_SRD_LSB +: 8];
    a.size = w[`MPR_SIZE_LSB +: 5];
    a.enable = w[`MPR_ENABLE_BIT];
    return a;
  endfunction

  // Clears base bits below the region size; the largest code clears all.
  function automatic logic [31:0] base_masked(input logic [26:0] b,
                                              input logic [4:0]  sz);
    logic [31:0] w;
    w = `MPR_RESET_WORD;
    for (int i = `MPR_BASE_LOW_BIT; i < 32; i++) begin
      w[i] = b[i - `MPR_BASE_LOW_BIT] & (i > int'(sz));
    end
    return w;
  endfunction

  logic [2:0]          region_sel;
  logic [26:0]         base_mem [0:`MPR_REGIONS-1];
  mpr_pkg::mpr_attr_t  attr_mem [0:`MPR_REGIONS-1];

  wire logic [5:0]     word_addr;
  wire logic           hit_number;
  wire logic           hit_base;
  wire logic           hit_attr;
  wire logic           wr_number;
  wire logic           wr_base;
  wire logic           wr_attr;
  wire logic           wr_valid;
  wire logic [2:0]     wr_region;
  wire logic [2:0]     base_target;
  wire logic [31:0]    attr_cur_word;
  wire logic [31:0]    attr_merged;
  wire logic [31:0]    base_read;
  wire logic [31:0]    number_read;
  wire logic [31:0]    next_rdata;
  wire mpr_pkg::mpr_attr_t attr_cur;
  wire mpr_pkg::mpr_attr_t next_attr;

  assign word_addr  = BUS_ADDR[7:2];

  // Primary and alias decode to the same storage.
  assign hit_number = word_addr == `MPR_OFS_REGION_NUMBER >> 2;
  assign hit_base   = (word_addr == `MPR_OFS_BASE >> 2) ||
                      (word_addr == `MPR_OFS_BASE_ALIAS_ONE >> 2);
  assign hit_attr   = (word_addr == `MPR_OFS_ATTR >> 2) ||
                      (word_addr == `MPR_OFS_ATTR_ALIAS_ONE >> 2);

  // Halfword writes reach only the attribute register.
  assign wr_number  = BUS_WRITE && hit_number && !BUS_HALF;
  assign wr_base    = BUS_WRITE && hit_base && !BUS_HALF;
  assign wr_attr    = BUS_WRITE && hit_attr;

  assign wr_valid   = BUS_WDATA[`MPR_BASE_VALID_BIT];
  assign wr_region  = BUS_WDATA[`MPR_REGION_MSB:0];

  // Valid set steers the base to the written region.
  assign base_target = wr_valid ? wr_region : region_sel;

  // Attribute accesses always refer to the selected region.
  assign attr_cur      = attr_mem[region_sel];
  assign attr_cur_word = attr_to_word(attr_cur);

  // Upper halfword holds attributes, lower holds size and enables.
  assign attr_merged = !BUS_HALF ? BUS_WDATA :
                       BUS_ADDR[1] ? {BUS_WDATA[31:16], attr_cur_word[15:0]} :
                       {attr_cur_word[31:16], BUS_WDATA[15:0]};
  assign next_attr   = word_to_attr(attr_merged);

  assign number_read = {29'h0, region_sel};

  // Valid reads zero; region field shows the region number register.
  assign base_read = base_masked(base_mem[region_sel], attr_cur.size) |
                     {27'h0, 1'b0, 1'b0, region_sel};

  // Unmapped addresses read zero.
  assign next_rdata = !BUS_READ  ? `MPR_RESET_WORD :
                      hit_number ? number_read :
                      hit_base   ? base_read :
                      hit_attr   ? attr_cur_word : `MPR_RESET_WORD;

  // Region number register.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      region_sel <= `MPR_RESET_REGION;
    end else if (wr_number) begin
      region_sel <= wr_region;
    end else if (wr_base && wr_valid) begin
      region_sel <= wr_region;
    end
  end

  // Read data stands for the cycle after the read strobe only.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      BUS_RDATA <= `MPR_RESET_WORD;
    end else begin
      BUS_RDATA <= next_rdata;
    end
  end

  assign REGION_SEL = region_sel;

  // Per-region storage and registered configuration outputs.
  generate
    for (genvar r = 0; r < `MPR_REGIONS; r++) begin : g_region
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          base_mem[r] <= 27'h0;
        end else if (wr_base && (base_target == 3'(r))) begin
          base_mem[r] <= BUS_WDATA[31:`MPR_BASE_LOW_BIT];
        end
      end

      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          attr_mem[r] <= '0;
        end else if (wr_attr && (region_sel == 3'(r))) begin
          attr_mem[r] <= next_attr;
        end
      end

      // Effective base honours the size; size code 31 yields zero.
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          REGION_CFG[r] <= '0;
        end else begin
          REGION_CFG[r].base <= base_masked(base_mem[r],
                                            attr_mem[r].size);
          REGION_CFG[r].attr <= attr_mem[r];
        end
      end
    end
  endgenerate

endmodule // mpr_region_regs

// ### testbench/mpr_asserts.sv
// Port assertions for the region configuration registers.
`timescale 1ns/1ps
`include "mpr_params.svh"
module mpr_asserts (
  input wire logic                       CLOCK,
  input wire logic                       RST_N,
  input wire logic [7:0]                 BUS_ADDR,
  input wire logic [31:0]                BUS_WDATA,
  input wire logic                       BUS_WRITE,
  input wire logic                       BUS_READ,
  input wire logic                       BUS_HALF,
  input wire logic [31:0]                BUS_RDATA,
  input wire logic [2:0]                 REGION_SEL,
  input wire mpr_pkg::mpr_region_t [7:0] REGION_CFG
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire is_base = BUS_ADDR == 8'h9C || BUS_ADDR == 8'hA4;
  wire is_attr = BUS_ADDR == 8'hA0 || BUS_ADDR == 8'hA8;
  wire mpr_pkg::mpr_region_t cur = REGION_CFG[REGION_SEL];
  wire [31:0] low_m = (32'h2 << cur.attr.size) - 32'h1;
  sequence base_rd; BUS_READ && is_base; endsequence
  sequence attr_wr; BUS_WRITE && !BUS_HALF && is_attr; endsequence
  sequence sel_wr; BUS_WRITE && !BUS_HALF && is_base; endsequence
  valid_zero_a: assert property (base_rd |=> BUS_RDATA[4:3] == 2'h0)
    else $error("valid bit read back set");
  region_read_a: assert property
    (base_rd |=> BUS_RDATA[2:0] == $past(REGION_SEL))
    else $error("bad region");
  sel_load_a: assert property
    (sel_wr ##0 BUS_WDATA[4] |=> REGION_SEL == $past(BUS_WDATA[2:0]))
    else $error("region number not loaded");
  sel_keep_a: assert property
    (sel_wr ##0 !BUS_WDATA[4] |=> $stable(REGION_SEL))
    else $error("region number moved");
  attr_resv_a: assert property
    (BUS_READ && is_attr |=> (BUS_RDATA & ~32'h173F_FF3F) == 32'h0)
    else $error("reserved attribute bits set");
  base_mask_a: assert property ((cur.base & low_m) == 32'h0)
    else $error("base bits below size kept");
  full_map_a: assert property
    (cur.attr.size == 5'h1F |-> cur.base == 32'h0)
    else $error("full map base not zero");
  xn_store_a: assert property (attr_wr |-> ##2
    REGION_CFG[$past(REGION_SEL, 2)].attr.no_execute ==
    $past(BUS_WDATA[28], 2)) else $error("no execute not stored");
  srd_store_a: assert property (attr_wr |-> ##2
    REGION_CFG[$past(REGION_SEL, 2)].attr.subregion_disable ==
    $past(BUS_WDATA[15:8], 2)) else $error("bad srd");
endmodule // mpr_asserts
bind mpr_region_regs mpr_asserts mpr_asserts_inst (
  .CLOCK      (CLOCK),
  .RST_N      (RST_N),
  .BUS_ADDR   (BUS_ADDR),
  .BUS_WDATA  (BUS_WDATA),
  .BUS_WRITE  (BUS_WRITE),
  .BUS_READ   (BUS_READ),
  .BUS_HALF   (BUS_HALF),
  .BUS_RDATA  (BUS_RDATA),
  .REGION_SEL (REGION_SEL),
  .REGION_CFG (REGION_CFG)
);

// ### testbench/mpr_core_model.sv
// Core-side model that reads fetch permission of the selected region.
`timescale 1ns/1ps
module mpr_core_model (
  input wire logic [2:0]                 sel,
  input wire mpr_pkg::mpr_region_t [7:0] cfg,
  output logic                           fetch_ok
);
  assign fetch_ok = cfg[sel].attr.enable &
                    ~cfg[sel].attr.no_execute;
endmodule // mpr_core_model

// ### testbench/mpr_region_config_regs_bench.sv
// Self-checking bench for the region configuration registers.
`timescale 1ns/1ps
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin \
  error_cnt++; $display("mismatch %0t %s", $time, m); end end
module mpr_region_config_regs_bench;
  logic CLOCK = 0, RST_N = 0, BUS_WRITE = 0, BUS_READ = 0, BUS_HALF = 0;
  logic [7:0] BUS_ADDR = 8'h0;
  logic [31:0] BUS_WDATA = 32'h0, BUS_RDATA, d, b, bw;
  logic [55:0] cfg_exp;
  logic [2:0] REGION_SEL;
  logic fetch_ok, rd_d = 0;
  mpr_pkg::mpr_region_t [7:0] REGION_CFG;
  logic [31:0] exp_q[$];
  int error_cnt = 0, compares = 0, seed = 57, sz;
  always #20 CLOCK = ~CLOCK;
  mpr_region_regs mpr_region_regs_inst (
    .CLOCK      (CLOCK),
    .RST_N      (RST_N),
    .BUS_ADDR   (BUS_ADDR),
    .BUS_WDATA  (BUS_WDATA),
    .BUS_WRITE  (BUS_WRITE),
    .BUS_READ   (BUS_READ),
    .BUS_HALF   (BUS_HALF),
    .BUS_RDATA  (BUS_RDATA),
    .REGION_SEL (REGION_SEL),
    .REGION_CFG (REGION_CFG)
  );
  mpr_core_model mpr_core_model_inst (.sel(REGION_SEL), .cfg(REGION_CFG),
    .fetch_ok(fetch_ok));
  task automatic bus(input w, input [7:0] a, input [31:0] v, input h);
    BUS_WRITE <= w;
    BUS_READ <= !w;
    BUS_ADDR <= a;
    BUS_WDATA <= v;
    BUS_HALF <= h;
    if (!w) exp_q.push_back(v);
    @(posedge CLOCK);
  endtask
  task automatic idle;
    BUS_WRITE <= 1'b0;
    BUS_READ <= 1'b0;
    repeat (2) @(posedge CLOCK);
  endtask
  task automatic close_out;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    rd_d <= BUS_READ;
    if (rd_d) `CHK(BUS_RDATA, exp_q.pop_front(), "read data")
  end
  initial begin
    #40us;
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    for (int a = 8'h98; a <= 8'hAC; a += 4) bus(0, a[7:0], 32'h0, 0);
    idle;
    $display("test reset done");
    for (int r = 0; r < 8; r++) begin
      sz = (r == 7) ? 31 : 4 + $unsigned($random(seed)) % 27;
      b = $random(seed) & ~((32'h2 << sz) - 32'h1);
      d = $random(seed) & 32'h173F_FF3F;
      d[5:0] = {sz[4:0], 1'b1};
      if (sz <= 6) d[15:8] = 8'h0;
      bw = (r == 7) ? 32'hFFFF_FFE0 : b;
      bus(1, r[0] ? 8'hA4 : 8'h9C, bw | 32'h10 | r, 0);
      bus(1, r[0] ? 8'hA8 : 8'hA0, d, 0);
      bus(0, 8'h98, r, 0);
      bus(0, 8'h9C, b | r, 0);
      bus(0, 8'hA8, d, 0);
      idle;
      cfg_exp = {b, d[28], d[26:24], d[21:16], d[15:8], d[5:0]};
      `CHK(REGION_CFG[r], cfg_exp, "cfg")
      `CHK(fetch_ok, !d[28], "fetch")
    end
    $display("test regions done");
    bus(1, 8'h98, 32'hFA, 0);
    bus(1, 8'h9C, 32'h8000_0005, 0);
    bus(1, 8'h9C, 32'h0000_0014, 1);
    bus(0, 8'h98, 32'h2, 0);
    bus(0, 8'hA4, 32'h8000_0002, 0);
    idle;
    `CHK(REGION_CFG[2].base, 32'h8000_0000, "base")
    `CHK(REGION_SEL, 3'h2, "sel")
    $display("test valid clear done");
    bus(1, 8'hA2, 32'h1234_0000, 1);
    bus(1, 8'hA0, 32'h0000_0009, 1);
    bus(0, 8'hA0, 32'h1234_0009, 1);
    idle;
    `CHK(REGION_CFG[2].attr, 24'hAD_0009, "half")
    $display("test halfword done");
    close_out;
  end
endmodule // mpr_region_config_regs_bench
